// ===== design/rit_pkg.sv
/*
  Constants for the RAM, I/O and timer peripheral with edge interrupt.
  Assumes a single 40 MHz core clock and a synchronous active-high reset.
*/
// Notes on behaviour
// - Two flags, timer and edge, both returned on a flag register read.
// - A flag register read clears the edge flag unless an edge sets it that cycle.
// - Timer read or write clears timer flag; flag read leaves it alone.
// - Selected only when high select is high and low select is low.
// - Register-space select low picks RAM, high picks I/O and timer.
// - A2 high picks timer or flags; on reads A0 low timer, high flags.
// - A1:A0 pick port A latch, A direction, B latch, B direction.
// - Timer write needs A4 high; A1:A0 pick 1, 8, 64, 1024 clocks.
// - Every timer access latches A3 as timer interrupt enable.
// - Active edge on port A bit 7 sets flag bit 6, may raise request.
// - Edge control updates on write, A4 low, A2 high; data ignored.
// - Edge control write: A1 enables or disables edge interrupt path.
// - Edge control write: A0 low falling edge, high rising edge.
// - Edge flag sets regardless of pin direction; only request is gated.
// - Reset disables edge interrupt and selects falling edge.
// - Timer flag in bit 7 sets on timeout whether enabled or not.
// - After zero, next count times out, loads ones, then counts every clock.
// - Timer read in the timeout cycle leaves the timer flag set.
// - RAM of 128 bytes addressed by seven low address lines.
package rit_pkg;
  localparam int unsigned RIT_RAM_DEPTH = 128;
  localparam logic [1:0] RIT_PORT_A_LATCH = 2'h0;
  localparam logic [1:0] RIT_PORT_A_DIR = 2'h1;
  localparam logic [1:0] RIT_PORT_B_LATCH = 2'h2;
  localparam logic [1:0] RIT_PORT_B_DIR = 2'h3;
  localparam int unsigned RIT_TIMER_FLAG_BIT = 7;
  localparam int unsigned RIT_EDGE_FLAG_BIT = 6;
  localparam logic [7:0] RIT_REG_RESET = 8'h00;
  localparam logic [7:0] RIT_TIMER_RESET = 8'hff;
  localparam logic [1:0] RIT_PRESCALE_RESET = 2'h0;
  localparam logic [9:0] RIT_DIV_1 = 10'h000;
  localparam logic [9:0] RIT_DIV_8 = 10'h007;
  localparam logic [9:0] RIT_DIV_64 = 10'h03f;
  localparam logic [9:0] RIT_DIV_1024 = 10'h3ff;
endpackage : rit_pkg

// ===== design/rit_core.sv
/*
  Register select, port registers, RAM, interval timer and interrupt logic.
  Assumes bus strobes from one access per asserted i_bus_strobe cycle, on
  the core clock; port pins arrive asynchronously and are synchronised.
*/
`timescale 1ns/1ps
module rit_core
  import rit_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_bus_strobe,
  input wire logic i_read_not_write,
  input wire logic i_chip_select_high,
  input wire logic i_chip_select_low_n,
  input wire logic i_register_space_select_n,
  input wire logic [6:0] i_addr,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_rdata,
  output logic o_rdata_oe,
  input wire logic [7:0] i_port_a_pins,
  input wire logic [7:0] i_port_b_pins,
  output logic [7:0] o_port_a_out,
  output logic [7:0] o_port_a_oe,
  output logic [7:0] o_port_b_out,
  output logic [7:0] o_port_b_oe,
  output logic o_irq_out,
  output logic o_irq_oe
);
  logic [7:0] mem_q [RIT_RAM_DEPTH];
  logic [7:0] pa_latch_q, pa_dir_q, pb_latch_q, pb_dir_q;
  logic [7:0] pa_s1_q, pa_s2_q, pb_s1_q, pb_s2_q;
  logic pa7_prev_q;
  logic [7:0] timer_q;
  logic [9:0] presc_cnt_q;
  logic [1:0] presc_sel_q;
  logic overrun_q;
  logic timer_flag_q, edge_flag_q;
  logic timer_ie_q, edge_ie_q, edge_rising_q;
  logic [7:0] rdata_q;
  logic rdata_oe_q;

  function automatic logic [9:0] div_of(input logic [1:0] sel);
    case (sel)
      2'h0: div_of = RIT_DIV_1;
      2'h1: div_of = RIT_DIV_8;
      2'h2: div_of = RIT_DIV_64;
      default: div_of = RIT_DIV_1024;
    endcase
  endfunction : div_of

  wire sel = i_bus_strobe & i_chip_select_high & ~i_chip_select_low_n;
  wire ram_acc = sel & ~i_register_space_select_n;
  wire io_acc = sel & i_register_space_select_n;
  wire port_acc = io_acc & ~i_addr[2];
  wire tf_acc = io_acc & i_addr[2];
  wire timer_wr = tf_acc & ~i_read_not_write & i_addr[4];
  wire timer_rd = tf_acc & i_read_not_write & ~i_addr[0];
  wire flag_rd = tf_acc & i_read_not_write & i_addr[0];
  wire edge_wr = tf_acc & ~i_read_not_write & ~i_addr[4];
  wire port_wr = port_acc & ~i_read_not_write;
  wire [1:0] port_sel = i_addr[1:0];
  wire tick = (presc_cnt_q == 10'h000) | overrun_q;
  wire timeout = tick & (timer_q == 8'h00) & ~timer_wr;
  wire pa7_now = pa_s2_q[7];
  wire edge_ev = edge_rising_q ? (pa7_now & ~pa7_prev_q)
                               : (~pa7_now & pa7_prev_q);
  wire [7:0] flags_w = {timer_flag_q, edge_flag_q, 6'h00};
  wire [7:0] port_rd_w = (port_sel == RIT_PORT_A_LATCH) ? pa_s2_q :
                         (port_sel == RIT_PORT_A_DIR) ? pa_dir_q :
                         (port_sel == RIT_PORT_B_LATCH) ? pb_latch_q :
                         pb_dir_q;
  // Port B reads the latch so loaded push-pull pins still read back true
  wire [7:0] rd_mux = ram_acc ? mem_q[i_addr] :
                      port_acc ? port_rd_w :
                      flag_rd ? flags_w : timer_q;

  always_ff @(posedge i_core_clk)
  begin
    pa_s1_q <= i_port_a_pins;
    pa_s2_q <= pa_s1_q;
    pb_s1_q <= i_port_b_pins;
    pb_s2_q <= pb_s1_q;
    pa7_prev_q <= pa_s2_q[7];
  end

  always_ff @(posedge i_core_clk)
  begin
    if (ram_acc && !i_read_not_write)
      mem_q[i_addr] <= i_wdata;
  end

  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
    begin
      pa_latch_q <= RIT_REG_RESET;
      pa_dir_q <= RIT_REG_RESET;
      pb_latch_q <= RIT_REG_RESET;
      pb_dir_q <= RIT_REG_RESET;
    end
    else if (port_wr)
    begin
      case (port_sel)
        RIT_PORT_A_LATCH: pa_latch_q <= i_wdata;
        RIT_PORT_A_DIR: pa_dir_q <= i_wdata;
        RIT_PORT_B_LATCH: pb_latch_q <= i_wdata;
        RIT_PORT_B_DIR: pb_dir_q <= i_wdata;
        default: pa_latch_q <= pa_latch_q;
      endcase
    end
  end

  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
    begin
      timer_q <= RIT_TIMER_RESET;
      presc_sel_q <= RIT_PRESCALE_RESET;
      presc_cnt_q <= RIT_DIV_1;
      overrun_q <= 1'b0;
      timer_ie_q <= 1'b0;
    end
    else
    begin
      if (timer_wr || timer_rd)
        timer_ie_q <= i_addr[3];
      if (timer_wr)
      begin
        timer_q <= i_wdata;
        presc_sel_q <= i_addr[1:0];
        presc_cnt_q <= div_of(i_addr[1:0]);
        overrun_q <= 1'b0;
      end
      else
      begin
        // Overrun counts each clock until the next write
        presc_cnt_q <= (presc_cnt_q == 10'h000) ?
                       div_of(presc_sel_q) : presc_cnt_q - 10'h001;
        if (tick)
          timer_q <= timer_q - 8'h01;
        if (timeout)
          overrun_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
    begin
      timer_flag_q <= 1'b0;
      edge_flag_q <= 1'b0;
      edge_ie_q <= 1'b0;
      edge_rising_q <= 1'b0;
    end
    else
    begin
      // Set wins over the clear in the same cycle
      if (timeout)
        timer_flag_q <= 1'b1;
      else if (timer_wr || timer_rd)
        timer_flag_q <= 1'b0;
      if (edge_ev)
        edge_flag_q <= 1'b1;
      else if (flag_rd)
        edge_flag_q <= 1'b0;
      if (edge_wr)
      begin
        edge_ie_q <= i_addr[1];
        edge_rising_q <= i_addr[0];
      end
    end
  end

  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
    begin
      rdata_q <= RIT_REG_RESET;
      rdata_oe_q <= 1'b0;
    end
    else
    begin
      rdata_oe_q <= sel & i_read_not_write;
      if (sel && i_read_not_write)
        rdata_q <= rd_mux;
    end
  end

  assign o_rdata = rdata_q;
  assign o_rdata_oe = rdata_oe_q;
  assign o_port_a_out = pa_latch_q;
  assign o_port_a_oe = pa_dir_q;
  assign o_port_b_out = pb_latch_q;
  assign o_port_b_oe = pb_dir_q;
  assign o_irq_out = 1'b0;
  assign o_irq_oe = (timer_flag_q & timer_ie_q) |
                    (edge_flag_q & edge_ie_q);

  a_edge_rst: assert property (@(posedge i_core_clk)
    i_rst |=> !edge_ie_q && !edge_rising_q)
    else $error("edge control not cleared by reset");
  a_sel_gate: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (i_bus_strobe && i_read_not_write && !(i_chip_select_high &&
     !i_chip_select_low_n)) |=> !o_rdata_oe)
    else $error("unselected read drove data");
  a_flag_clr: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (flag_rd && !edge_ev) |=> !edge_flag_q)
    else $error("edge flag not cleared by flag read");
  a_flag_keep: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (flag_rd && timer_flag_q && !timer_wr) |=> timer_flag_q)
    else $error("flag read cleared timer flag");
  a_timer_clr: assert property (@(posedge i_core_clk) disable iff (i_rst)
    ((timer_wr || timer_rd) && !timeout) |=> !timer_flag_q)
    else $error("timer access did not clear flag");
  a_timeout_set: assert property (@(posedge i_core_clk) disable iff (i_rst)
    timeout |=> timer_flag_q && timer_q == 8'hff)
    else $error("timeout did not set flag and load ones");
  a_edge_set: assert property (@(posedge i_core_clk) disable iff (i_rst)
    edge_ev |=> edge_flag_q)
    else $error("edge event lost");
  a_ie_latch: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (timer_wr || timer_rd) |=> timer_ie_q == $past(i_addr[3]))
    else $error("timer enable not latched");
  a_irq_drive: assert property (@(posedge i_core_clk) disable iff (i_rst)
    o_irq_oe == ((timer_flag_q && timer_ie_q) ||
                 (edge_flag_q && edge_ie_q)))
    else $error("request level wrong");
  a_edge_ctl: assert property (@(posedge i_core_clk) disable iff (i_rst)
    edge_wr |=> edge_ie_q == $past(i_addr[1]) &&
                edge_rising_q == $past(i_addr[0]))
    else $error("edge control not updated");

  // Bus side steps are named once and each used by one property below
  sequence s_rd_taken;
    sel && i_read_not_write;
  endsequence
  sequence s_ram_store;
    ram_acc && !i_read_not_write;
  endsequence

  a_rd_answer: assert property (@(posedge i_core_clk) disable iff (i_rst)
    s_rd_taken |=> o_rdata_oe)
    else $error("selected read gave no answer");
  a_wr_quiet: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (i_bus_strobe && !i_read_not_write) |=> !o_rdata_oe)
    else $error("write drove data bus");
  a_rd_hold: assert property (@(posedge i_core_clk) disable iff (i_rst)
    !(sel && i_read_not_write) |=> $stable(o_rdata))
    else $error("read data changed without read");
  a_ram_store: assert property (@(posedge i_core_clk) disable iff (i_rst)
    s_ram_store |=> mem_q[$past(i_addr)] == $past(i_wdata))
    else $error("ram write lost");
  a_ram_fetch: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (ram_acc && i_read_not_write) |=> o_rdata == $past(mem_q[i_addr]))
    else $error("ram read wrong");
  a_dir_a_wr: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (port_wr && port_sel == RIT_PORT_A_DIR) |=>
      o_port_a_oe == $past(i_wdata))
    else $error("port a direction write lost");
  a_latch_b_wr: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (port_wr && port_sel == RIT_PORT_B_LATCH) |=>
      o_port_b_out == $past(i_wdata))
    else $error("port b latch write lost");
  a_flag_data: assert property (@(posedge i_core_clk) disable iff (i_rst)
    flag_rd |=> o_rdata[7] == $past(timer_flag_q) &&
      o_rdata[6] == $past(edge_flag_q) && o_rdata[5:0] == 6'h00)
    else $error("flag read data wrong");
  a_timer_load: assert property (@(posedge i_core_clk) disable iff (i_rst)
    timer_wr |=> timer_q == $past(i_wdata) &&
      presc_sel_q == $past(i_addr[1:0]))
    else $error("timer write not loaded");
  a_eflag_keep: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (!edge_ev && !flag_rd) |=> edge_flag_q == $past(edge_flag_q))
    else $error("edge flag changed alone");
  a_tflag_keep: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (!timeout && !timer_wr && !timer_rd) |=>
      timer_flag_q == $past(timer_flag_q))
    else $error("timer flag changed alone");
  a_ie_hold: assert property (@(posedge i_core_clk) disable iff (i_rst)
    !(timer_wr || timer_rd) |=> timer_ie_q == $past(timer_ie_q))
    else $error("timer enable changed alone");
  a_overrun_rate: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (overrun_q && !timer_wr) |=> timer_q == $past(timer_q) - 8'h01)
    else $error("overrun not counting every clock");
  a_irq_level: assert property (@(posedge i_core_clk) disable iff (i_rst)
    o_irq_out == 1'b0)
    else $error("request line not pulled low");
endmodule : rit_core

// ===== tb/rit_cpu_model.sv
/*
  Processor bus master model for the RAM, I/O and timer block.
  Assumes the bench clock; signals change at falling edges only.
*/
`timescale 1ns/1ps
module rit_cpu_model (
  input wire logic i_core_clk,
  input wire logic [7:0] i_rdata,
  input wire logic i_rdata_oe,
  output logic o_bus_strobe,
  output logic o_read_not_write,
  output logic o_chip_select_high,
  output logic o_chip_select_low_n,
  output logic o_register_space_select_n,
  output logic [6:0] o_addr,
  output logic [7:0] o_wdata
);
  initial
  begin
    o_bus_strobe = 1'b0;
    o_read_not_write = 1'b1;
    {o_chip_select_high, o_chip_select_low_n} = 2'h1;
    o_register_space_select_n = 1'b1;
    o_addr = 7'h00;
    o_wdata = 8'h00;
  end
  task automatic acc(input logic sel, input logic rnw, input logic rs,
    input logic [6:0] a, input logic [7:0] d, output logic [7:0] q,
    output logic oe);
    @(negedge i_core_clk);
    {o_chip_select_high, o_chip_select_low_n} = {sel, 1'b0};
    o_register_space_select_n = rs;
    o_read_not_write = rnw;
    o_addr = a;
    o_wdata = d;
    o_bus_strobe = 1'b1;
    @(negedge i_core_clk);
    // Read enable stands only this cycle, so take the answer before release
    q = i_rdata;
    oe = i_rdata_oe;
    o_bus_strobe = 1'b0;
    // Released address and data show their inverse, never the last value; read/write and space select keep theirs
    {o_chip_select_high, o_chip_select_low_n} = 2'h1;
    o_addr = ~a;
    o_wdata = ~d;
  endtask : acc
endmodule : rit_cpu_model

// ===== tb/rit_core_tb.sv
/*
  Self-checking bench for the RAM, I/O and timer block.
  Assumes the processor model drives the bus; port pins driven here.
*/
`timescale 1ns/1ps
module rit_core_tb;
  import rit_pkg::*;
  logic clk, rst, stb, rnw, csh, csl_n, rs_n, rdoe, irq, irq_oe, oe;
  logic [6:0] addr;
  logic [7:0] wd, rd_q, pa, pb, pa_o, pa_oe, pb_o, pb_oe, q;
  logic [7:0] regs [4];
  int seed = 32'h5454;
  int error_cnt = 0;
  int checked = 0;
  int i, n;
  rit_core DUT (.i_core_clk(clk), .i_rst(rst), .i_bus_strobe(stb),
    .i_read_not_write(rnw), .i_chip_select_high(csh),
    .i_chip_select_low_n(csl_n), .i_register_space_select_n(rs_n),
    .i_addr(addr), .i_wdata(wd), .o_rdata(rd_q), .o_rdata_oe(rdoe),
    .i_port_a_pins(pa), .i_port_b_pins(pb), .o_port_a_out(pa_o),
    .o_port_a_oe(pa_oe), .o_port_b_out(pb_o), .o_port_b_oe(pb_oe),
    .o_irq_out(irq), .o_irq_oe(irq_oe));
  rit_cpu_model cpu (.i_core_clk(clk), .i_rdata(rd_q), .i_rdata_oe(rdoe),
    .o_bus_strobe(stb), .o_read_not_write(rnw), .o_chip_select_high(csh),
    .o_chip_select_low_n(csl_n), .o_register_space_select_n(rs_n),
    .o_addr(addr), .o_wdata(wd));
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic stop_test;
    $display("checked %0d, mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : stop_test
  task automatic rd(input logic [6:0] a);
    cpu.acc(1'b1, 1'b1, 1'b1, a, 8'h00, q, oe);
  endtask : rd
  task automatic wr(input logic [6:0] a, input logic [7:0] v);
    cpu.acc(1'b1, 1'b0, 1'b1, a, v, q, oe);
  endtask : wr
  task automatic idle(input int c);
    repeat (c) @(negedge clk);
  endtask : idle
  function automatic logic [7:0] flags(input logic t, input logic e);
    return {t, e, 6'h00};
  endfunction : flags
  function automatic int div_of(input int k);
    return (k == 3) ? 1024 : 1 << (3 * k);
  endfunction : div_of
  initial
  begin
    rst = 1'b1;
    pa = 8'hff;
    pb = 8'($random(seed));
    idle(8);
    rst = 1'b0;
    rd(7'h05);
    check(q, flags(1'b0, 1'b0));
    for (i = 1; i < 4; i++)
    begin
      rd(7'(i));
      check(q, RIT_REG_RESET);
    end
    $display("test reset done");
    for (i = 0; i < 4; i++)
    begin
      regs[i] = 8'($random(seed));
      wr(7'(i), regs[i]);
      rd(7'(i));
      if (i != 0)
        check(q, regs[i]);
      check({7'h00, oe}, 8'h01);
    end
    cpu.acc(1'b0, 1'b1, 1'b1, 7'h01, 8'h00, q, oe);
    check({7'h00, oe}, 8'h00);
    cpu.acc(1'b0, 1'b0, 1'b1, 7'h01, ~regs[1], q, oe);
    cpu.acc(1'b1, 1'b0, 1'b0, 7'h01, ~regs[1], q, oe);
    check(pa_oe, regs[1]);
    check(pa_o, regs[0]);
    check(pb_o, regs[2]);
    check(pb_oe, regs[3]);
    pa = {1'b1, 7'($random(seed))};
    idle(4);
    rd(7'h00);
    check(q, pa);
    $display("test registers done");
    for (i = 0; i < 8; i++)
      cpu.acc(1'b1, 1'b0, 1'b0, 7'(i * 18 + 1), 8'(i * 29 + 3), q, oe);
    for (i = 0; i < 8; i++)
    begin
      cpu.acc(1'b1, 1'b1, 1'b0, 7'(i * 18 + 1), 8'h00, q, oe);
      check(q, 8'(i * 29 + 3));
    end
    wr(7'h01, 8'h80);
    pa[7] = 1'b0;
    idle(4);
    check({7'h00, irq_oe}, 8'h00);
    rd(7'h05);
    check(q, flags(1'b0, 1'b1));
    rd(7'h05);
    check(q, flags(1'b0, 1'b0));
    wr(7'h07, 8'h5a);
    pa[7] = 1'b1;
    idle(4);
    check({7'h00, irq_oe}, 8'h01);
    rd(7'h05);
    check({7'h00, irq_oe}, 8'h00);
    $display("test edge done");
    wr(7'h14, 8'h40);
    rd(7'h04);
    check(q, 8'h3f);
    wr(7'h1c, 8'h02);
    n = 0;
    while (irq_oe !== 1'b1 && n < 100)
    begin
      idle(1);
      n++;
    end
    if (n == 100)
    begin
      error_cnt++;
      stop_test();
    end
    rd(7'h05);
    check(q, flags(1'b1, 1'b0));
    rd(7'h04);
    check({7'h00, irq_oe}, 8'h00);
    rd(7'h05);
    check(q, flags(1'b0, 1'b0));
    for (i = 1; i < 4; i++)
    begin
      wr(7'(8'h14 + i), 8'h01);
      rd(7'h05);
      check(q, flags(1'b0, 1'b0));
      idle(3 * div_of(i));
      rd(7'h05);
      check(q, flags(1'b1, 1'b0));
      check({7'h00, irq_oe}, 8'h00);
      rd(7'h04);
    end
    $display("test timer done");
    stop_test();
  end
endmodule : rit_core_tb
